// ==== hdl/sao_pkg.sv ====
// Constants shared by the sync and alert output logic
package sao_pkg;
  localparam int unsigned CLK_FREQ_HZ = 32'h0bebc200;
  localparam int unsigned PULSE_WIDTH_MS = 32'h0000000a;
  localparam int unsigned MAX_LATENCY_MS = 32'h00000023;
  localparam int unsigned PULSE_CYCLES = CLK_FREQ_HZ / 32'h000003e8 * PULSE_WIDTH_MS;
  localparam int unsigned LATENCY_CYCLES = CLK_FREQ_HZ / 32'h000003e8 * MAX_LATENCY_MS;
  localparam int unsigned TMR_W = 32'h00000016;
  localparam logic [TMR_W-1:0] TMR_ZERO = 22'h000000;
  localparam logic [TMR_W-1:0] TMR_ONE = 22'h000001;
  localparam logic [1:0] SYNC_CHAIN_W = 2'h3;
endpackage

// ==== hdl/sao_sync_if.sv ====
// Carrier for a synchronised pin input between modules
`timescale 1ns/100ps
interface sao_sync_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface

// ==== hdl/sao_in_sync.sv ====
// Three-stage synchroniser with agreement check and rise detect
`timescale 1ns/100ps
module sao_in_sync (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic pin_i,
  sao_sync_if.src out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sao_sync_st_type;
  sao_sync_st_type st_ff;
  sao_sync_st_type nxt_st;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = pin_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // A change counts only once stages two and three agree
    if (st_ff.s2 == st_ff.s3) begin
      nxt_st.level = st_ff.s3;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign out.level = st_ff.level;
  assign out.rise = (st_ff.s2 == st_ff.s3) && st_ff.s3 && !st_ff.level;
endmodule

// ==== hdl/sao_outputs.sv ====
// Defibrillator sync pulse and latched staff alert outputs
`timescale 1ns/100ps
module sao_outputs (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic sync_event_i,
  input wire logic red_alarm_i,
  input wire logic yellow_alarm_i,
  input wire logic alarm_mute_key_i,
  output logic defib_sync_o,
  output logic staff_alert_o
);
  sao_sync_if ev_if();
  sao_sync_if red_if();
  sao_sync_if yel_if();
  sao_sync_if mute_if();
  sao_in_sync u_ev (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .pin_i(sync_event_i),
    .out(ev_if));
  sao_in_sync u_red (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .pin_i(red_alarm_i),
    .out(red_if));
  sao_in_sync u_yel (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .pin_i(yellow_alarm_i),
    .out(yel_if));
  sao_in_sync u_mute (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .pin_i(alarm_mute_key_i), .out(mute_if));

  typedef enum logic [1:0] {
    SAO_IDLE = 2'h1,
    SAO_PULSE = 2'h2
  } sao_state_type;

  typedef struct packed {
    sao_state_type state;
    logic [sao_pkg::TMR_W-1:0] tmr;
    logic sync;
    logic alert;
  } sao_st_type;

  sao_st_type st_ff;
  sao_st_type nxt_st;
  logic alarm_any;
  logic alarm_rise;

  always_comb begin
    alarm_any = red_if.level | yel_if.level;
    alarm_rise = red_if.rise | yel_if.rise;
    nxt_st = st_ff;
    case (st_ff.state)
      SAO_IDLE: begin
        if (ev_if.rise) begin
          nxt_st.state = SAO_PULSE;
          nxt_st.sync = 1'b1;
          nxt_st.tmr = sao_pkg::TMR_ONE;
        end
      end
      SAO_PULSE: begin
        // New events are not looked at here
        if (st_ff.tmr == sao_pkg::TMR_W'(sao_pkg::PULSE_CYCLES)) begin
          nxt_st.state = SAO_IDLE;
          nxt_st.sync = 1'b0;
          nxt_st.tmr = sao_pkg::TMR_ZERO;
        end else begin
          nxt_st.tmr = st_ff.tmr + sao_pkg::TMR_ONE;
        end
      end
      default: begin
        nxt_st.state = SAO_IDLE;
        nxt_st.sync = 1'b0;
        nxt_st.tmr = sao_pkg::TMR_ZERO;
      end
    endcase
    // A fresh alarm edge wins over a mute pressed in the same cycle
    if (alarm_rise) begin
      nxt_st.alert = 1'b1;
    end else if (!alarm_any || mute_if.level) begin
      nxt_st.alert = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= '{state: SAO_IDLE, tmr: '0, sync: 1'b0, alert: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign defib_sync_o = st_ff.sync;
  assign staff_alert_o = st_ff.alert;

  // Named steps of a pulse and of the alert latch, shared by the checks below
  sequence seq_pulse_start;
    $rose(st_ff.sync);
  endsequence
  sequence seq_pulse_hold;
    st_ff.sync [*8];
  endsequence
  sequence seq_event_idle;
    st_ff.state == SAO_IDLE && ev_if.rise;
  endsequence
  sequence seq_pulse_mid;
    st_ff.sync && st_ff.tmr != sao_pkg::TMR_W'(sao_pkg::PULSE_CYCLES);
  endsequence
  sequence seq_pulse_last;
    st_ff.sync && st_ff.tmr == sao_pkg::TMR_W'(sao_pkg::PULSE_CYCLES);
  endsequence
  sequence seq_alarm_edge;
    red_if.rise || yel_if.rise;
  endsequence
  sequence seq_alert_quiet;
    !alarm_rise && !staff_alert_o;
  endsequence

  chk_pulse_on_event: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (st_ff.state == SAO_IDLE && ev_if.rise) |=> st_ff.sync)
    else $error("sync pulse did not start on event");
  chk_pulse_width_end: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (st_ff.sync && st_ff.tmr == sao_pkg::TMR_W'(sao_pkg::PULSE_CYCLES)) |=> !st_ff.sync)
    else $error("sync pulse did not end at width");
  chk_pulse_no_early: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (st_ff.sync && st_ff.tmr < sao_pkg::TMR_W'(sao_pkg::PULSE_CYCLES)) |=> st_ff.sync)
    else $error("sync pulse ended early");
  chk_pulse_no_retrig: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (st_ff.sync && ev_if.rise && st_ff.tmr != sao_pkg::TMR_W'(sao_pkg::PULSE_CYCLES))
    |=> $stable(st_ff.sync) && st_ff.tmr == $past(st_ff.tmr) + sao_pkg::TMR_ONE)
    else $error("sync pulse retriggered");
  chk_pulse_hold_min: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    seq_pulse_start |-> seq_pulse_hold)
    else $error("sync pulse too short");
  chk_sync_latency: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    $rose(sync_event_i) && st_ff.state == SAO_IDLE |-> ##[1:8] st_ff.sync)
    else $error("sync latency too long");
  chk_alert_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (red_if.rise || yel_if.rise) |=> staff_alert_o)
    else $error("alert not set by alarm");
  chk_alert_clear: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (!(red_if.rise || yel_if.rise) && (mute_if.level || !(red_if.level || yel_if.level)))
    |=> !staff_alert_o)
    else $error("alert not cleared");
  chk_alert_latch: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (staff_alert_o && (red_if.level || yel_if.level) && !mute_if.level) |=> staff_alert_o)
    else $error("alert dropped while latched");
  chk_reset_idle: assert property (@(posedge core_clk_i)
    !rst_b_i |-> !defib_sync_o && !staff_alert_o && st_ff.tmr == sao_pkg::TMR_ZERO)
    else $error("outputs not cleared in reset");

  // Pulse start: the timer and state are loaded together with the output
  chk_event_timer_load: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    seq_event_idle |=> st_ff.tmr == sao_pkg::TMR_ONE)
    else $error("pulse timer not loaded on event");
  chk_event_state_load: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    seq_event_idle |=> st_ff.state == SAO_PULSE)
    else $error("pulse state not entered on event");
  chk_sync_state_pair: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    st_ff.sync == (st_ff.state == SAO_PULSE))
    else $error("sync output and state disagree");
  chk_no_spurious_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (st_ff.state == SAO_IDLE && !ev_if.rise) |=> !st_ff.sync)
    else $error("sync pulse without event");
  chk_sync_rise_cause: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    seq_pulse_start |-> $past(ev_if.rise))
    else $error("sync rise without event edge");
  chk_event_level_follow: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ev_if.rise |=> ev_if.level)
    else $error("event level missed its edge");
  chk_event_rise_fresh: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ev_if.rise |-> !ev_if.level)
    else $error("event edge while already high");

  // A full width is far too long to simulate, so the timer is followed step by step
  chk_pulse_timer_nonzero: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    st_ff.sync |-> st_ff.tmr != sao_pkg::TMR_ZERO)
    else $error("pulse timer zero while active");
  chk_pulse_timer_cap: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    st_ff.sync |-> st_ff.tmr <= sao_pkg::TMR_W'(sao_pkg::PULSE_CYCLES))
    else $error("pulse timer beyond width");
  chk_pulse_timer_step: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    seq_pulse_mid |=> st_ff.tmr == $past(st_ff.tmr) + sao_pkg::TMR_ONE)
    else $error("pulse timer skipped a step");
  chk_pulse_end_idle: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    seq_pulse_last |=>
    st_ff.state == SAO_IDLE && st_ff.tmr == sao_pkg::TMR_ZERO)
    else $error("pulse end did not return to idle");
  chk_sync_fall_cause: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    $fell(st_ff.sync) |-> $past(st_ff.tmr) == sao_pkg::TMR_W'(sao_pkg::PULSE_CYCLES))
    else $error("sync fell before full width");

  // Events inside a pulse are dropped, never queued
  chk_pulse_state_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    seq_pulse_mid |=> st_ff.state == SAO_PULSE)
    else $error("pulse state left early");
  chk_pulse_event_kept: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (st_ff.sync && ev_if.rise) |=> st_ff.tmr != sao_pkg::TMR_ONE)
    else $error("pulse timer restarted by event");
  chk_sync_rise_idle: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    seq_pulse_start |-> $past(st_ff.state) == SAO_IDLE)
    else $error("sync rise outside idle");
  chk_event_rise_single: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ev_if.rise |=> !ev_if.rise)
    else $error("event edge counted twice");
  chk_event_to_sync: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    seq_event_idle |-> ##1 defib_sync_o)
    else $error("sync output late after event");

  // Alert latch: set wins over clear in one cycle
  chk_alarm_edge_level: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    seq_alarm_edge |=> alarm_any)
    else $error("alarm level missed its edge");
  chk_alert_rise_cause: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    $rose(staff_alert_o) |-> $past(alarm_rise))
    else $error("alert rose without alarm edge");
  chk_alert_quiet_stays: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    seq_alert_quiet |=> !staff_alert_o)
    else $error("alert set without alarm edge");
  chk_alert_set_muted: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (alarm_rise && mute_if.level) |=> staff_alert_o)
    else $error("mute blocked a fresh alarm");
  chk_alert_fall_cause: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    $fell(staff_alert_o) |-> !$past(alarm_any) || $past(mute_if.level))
    else $error("alert fell while alarm held");
  chk_mute_clears: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (!alarm_rise && mute_if.level) |=> !staff_alert_o)
    else $error("mute did not clear alert");
  chk_alarm_end_clears: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (!alarm_rise && !alarm_any) |=> !staff_alert_o)
    else $error("alarm end did not clear alert");

  chk_reset_state_idle: assert property (@(posedge core_clk_i)
    !rst_b_i |-> st_ff.state == SAO_IDLE)
    else $error("state not idle in reset");
  chk_reset_inputs_low: assert property (@(posedge core_clk_i)
    !rst_b_i |-> !red_if.level && !yel_if.level && !mute_if.level && !ev_if.level)
    else $error("synchronised inputs not cleared in reset");
endmodule

// ==== testbench/sao_far_end.sv ====
// Far-side model that counts sync pulses taken by the defibrillator
`timescale 1ns/100ps
module sao_far_end (
  input wire logic core_clk_i,
  input wire logic defib_sync_i,
  output int shock_count_o
);
  logic last_sync = 1'b0;
  int count_q = 0;
  assign shock_count_o = count_q;
  always @(posedge core_clk_i) begin
    if (defib_sync_i === 1'b1 && last_sync !== 1'b1) begin
      count_q <= count_q + 1;
    end
    last_sync <= defib_sync_i;
  end
endmodule

// ==== testbench/sync_and_alert_outputs_bench.sv ====
// Self-checking bench for the sync pulse and staff alert outputs
`timescale 1ns/100ps
module sync_and_alert_outputs_bench;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b1;
  logic sync_event_i = 1'b0;
  logic red_alarm_i = 1'b0;
  logic yellow_alarm_i = 1'b0;
  logic alarm_mute_key_i = 1'b0;
  logic defib_sync_o;
  logic staff_alert_o;
  int shocks;
  int failures = 0;
  int comparisons = 0;
  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  sao_outputs dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .sync_event_i(sync_event_i),
    .red_alarm_i(red_alarm_i), .yellow_alarm_i(yellow_alarm_i),
    .alarm_mute_key_i(alarm_mute_key_i), .defib_sync_o(defib_sync_o),
    .staff_alert_o(staff_alert_o));
  sao_far_end far_u (.core_clk_i(core_clk_i), .defib_sync_i(defib_sync_o), .shock_count_o(shocks));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic edges(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic test_alarm();
    @(posedge core_clk_i);
    red_alarm_i <= 1'b1;
    edges(3);
    check(staff_alert_o, 1'b0);
    edges(1);
    check(staff_alert_o, 1'b1);
    edges(20);
    check(staff_alert_o, 1'b1);
    @(posedge core_clk_i);
    alarm_mute_key_i <= 1'b1;
    edges(5);
    check(staff_alert_o, 1'b0);
    @(posedge core_clk_i);
    alarm_mute_key_i <= 1'b0;
    red_alarm_i <= 1'b0;
    yellow_alarm_i <= 1'b1;
    edges(5);
    check(staff_alert_o, 1'b1);
    @(posedge core_clk_i);
    yellow_alarm_i <= 1'b0;
    edges(5);
    check(staff_alert_o, 1'b0);
    $display("alarm test done");
  endtask
  // The full 10 ms pulse is too long to run; width is checked over a partial span
  task automatic test_sync();
    int i;
    @(posedge core_clk_i);
    sync_event_i <= 1'b1;
    edges(3);
    check(defib_sync_o, 1'b0);
    edges(1);
    check(defib_sync_o, 1'b1);
    @(posedge core_clk_i);
    sync_event_i <= 1'b0;
    edges(100);
    @(posedge core_clk_i);
    sync_event_i <= 1'b1;
    edges(40000);
    check(defib_sync_o, 1'b1);
    check(shocks, 1);
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    edges(1);
    check(defib_sync_o, 1'b0);
    @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    for (i = 0; i < 10 && defib_sync_o !== 1'b1; i++) edges(1);
    // A pin already high at reset release counts as a fresh event
    check(defib_sync_o, 1'b1);
    // The far end samples the new level one edge later
    edges(1);
    check(shocks, 2);
    $display("sync test done");
  endtask
  initial begin
    // Assert reset before the first edge so no flop is sampled unknown
    rst_b_i <= 1'b0;
    edges(10);
    @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    edges(1);
    check({defib_sync_o, staff_alert_o}, 2'h0);
    test_alarm();
    test_sync();
    test_done();
  end
endmodule
